// file: cwf_can_node.sv
module cwf_can_node
  import cwf_pkg::*;
(
  input  wire logic     ref_clk,
  output logic          frame_valid,
  output cwf_frame_type frame
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    frame_valid = 1'b0;
    frame = '0;
  end

  // one-cycle frame; fields scrambled once released so stale values never match
  task automatic send(input cwf_frame_type f);
    @(posedge ref_clk);
    #2;
    frame_valid = 1'b1;
    frame = f;
    @(posedge ref_clk);
    #2;
    frame_valid = 1'b0;
    frame = ~f;
  endtask
endmodule

// file: cwf_frame_compare.sv
module cwf_frame_compare
  import cwf_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire cwf_cfg_type   cfg,
  input  wire cwf_frame_type frame,
  output logic               id_hit,
  output logic               flags_hit,
  output logic               dlc_hit,
  output logic               match
);

  logic [CWF_ID_W-1:0]  ext_ok;
  logic [CWF_STD_W-1:0] std_ok;

  genvar gi;
  generate
    for (gi = 0; gi < CWF_ID_W; gi++) begin : g_ext
      // unmasked bits always pass
      assign ext_ok[gi] = ~cfg.mask[gi] | (cfg.ident[gi] == frame.ident[gi]);
    end
    for (gi = 0; gi < CWF_STD_W; gi++) begin : g_std
      // standard id sits in image bits 28..18
      assign std_ok[gi] = ~cfg.mask[CWF_STD_LSB+gi]
                          | (cfg.ident[CWF_STD_LSB+gi] == frame.ident[gi]);
    end
  endgenerate

  always_comb begin
    id_hit    = cfg.ide ? (&ext_ok) : (&std_ok);
    flags_hit = (frame.ide == cfg.ide) && (frame.rtr == cfg.rtr);
    dlc_hit   = (frame.dlc == cfg.dlc);
    match     = id_hit && flags_hit && dlc_hit;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_DLC_EXACT: assert property (match |-> frame.dlc == cfg.dlc)
    else $error("length code mismatch accepted");
  AST_MASK_IGNORE: assert property (
    (cfg.ide && cfg.mask == '0 && flags_hit && dlc_hit) |-> match)
    else $error("zero mask did not accept frame");
  AST_STD_FIELD: assert property (
    (!cfg.ide && match) |->
      ((cfg.ident[CWF_ID_W-1:CWF_STD_LSB] ^ frame.ident[CWF_STD_W-1:0])
       & cfg.mask[CWF_ID_W-1:CWF_STD_LSB]) == '0)
    else $error("standard id compared on wrong bits");

endmodule

// file: cwf_pkg.sv
package cwf_pkg;

  localparam logic [6:0] CWF_ADDR_CTRL       = 7'h20;
  localparam logic [6:0] CWF_ADDR_ID_TOP     = 7'h23;
  localparam logic [6:0] CWF_ADDR_ID_UMID    = 7'h24;
  localparam logic [6:0] CWF_ADDR_ID_LMID    = 7'h25;
  localparam logic [6:0] CWF_ADDR_ID_LOW     = 7'h26;
  localparam logic [6:0] CWF_ADDR_MASK_TOP   = 7'h27;
  localparam logic [6:0] CWF_ADDR_MASK_UMID  = 7'h28;
  localparam logic [6:0] CWF_ADDR_MASK_LMID  = 7'h29;
  localparam logic [6:0] CWF_ADDR_MASK_LOW   = 7'h2a;
  localparam logic [6:0] CWF_ADDR_DLC        = 7'h2b;

  localparam int         CWF_ID_W            = 29;
  localparam int         CWF_STD_W           = 11;
  localparam int         CWF_STD_LSB         = 18;
  localparam int         CWF_LOW_HI          = 6;
  localparam int         CWF_LOW_LO          = 2;
  localparam int         CWF_RTR_POS         = 1;
  localparam int         CWF_IDE_POS         = 0;
  localparam int         CWF_VALID_POS       = 0;
  localparam int         CWF_DLC_W           = 4;
  localparam logic [3:0] CWF_DLC_MAX_BYTES   = 4'h8;
  localparam logic [7:0] CWF_ZERO_BYTE       = 8'h00;
  localparam logic [7:0] CWF_ID_LOW_RSV      = 8'h80;
  localparam logic [7:0] CWF_MASK_LOW_RSV    = 8'h83;
  localparam logic [7:0] CWF_DLC_RSV         = 8'hf0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cwf_reg_req_type;

  typedef struct packed {
    logic                ide;
    logic                rtr;
    logic [CWF_ID_W-1:0] ident;
    logic [3:0]          dlc;
  } cwf_frame_type;

  typedef struct packed {
    logic [CWF_ID_W-1:0] ident;
    logic [CWF_ID_W-1:0] mask;
    logic                rtr;
    logic                ide;
    logic [3:0]          dlc;
  } cwf_cfg_type;

  typedef enum logic [1:0] {
    CWF_ST_UNCONF = 2'b01,
    CWF_ST_ARMED  = 2'b10
  } cwf_state_type;

  typedef struct packed {
    cwf_cfg_type   cfg;
    cwf_state_type st;
    logic [7:0]    rdata;
    logic          hit;
    logic [3:0]    bytes;
  } cwf_regs_type;

  localparam cwf_regs_type CWF_REGS_RESET = '{
    cfg:   '0,
    st:    CWF_ST_UNCONF,
    rdata: 8'h00,
    hit:   1'b0,
    bytes: 4'h0
  };

endpackage

// file: cwf_wake_filter.sv
module cwf_wake_filter
  import cwf_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            soft_reset,
  input  wire logic            restart,
  input  wire cwf_reg_req_type reg_req,
  output logic [7:0]           reg_rdata,
  input  wire logic            frame_valid,
  input  wire cwf_frame_type   frame,
  input  wire logic            ext_wake,
  output logic                 selective_wake_enable,
  output logic                 wake_up_frame_hit,
  output logic [3:0]           wake_frame_bytes
);

  cwf_regs_type r;
  cwf_regs_type n;
  logic         cmp_match;
  logic         armed;
  logic         cfg_write;
  logic         valid_set;
  logic         valid_clr;
  logic         hit_now;

  cwf_frame_compare u_compare (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .cfg       (r.cfg),
    .frame     (frame),
    .id_hit    (),
    .flags_hit (),
    .dlc_hit   (),
    .match     (cmp_match)
  );

  function automatic logic [3:0] dlc_bytes(input logic [3:0] code);
    // codes above eight all carry eight bytes
    if (code > CWF_DLC_MAX_BYTES) begin
      dlc_bytes = CWF_DLC_MAX_BYTES;
    end else begin
      dlc_bytes = code;
    end
  endfunction

  function automatic logic [7:0] read_byte(input logic [6:0] addr, input cwf_regs_type s);
    read_byte = CWF_ZERO_BYTE;
    case (addr)
      CWF_ADDR_CTRL: begin
        read_byte[CWF_VALID_POS] = (s.st == CWF_ST_ARMED);
      end
      CWF_ADDR_ID_TOP: begin
        read_byte = s.cfg.ident[28:21];
      end
      CWF_ADDR_ID_UMID: begin
        read_byte = s.cfg.ident[20:13];
      end
      CWF_ADDR_ID_LMID: begin
        read_byte = s.cfg.ident[12:5];
      end
      CWF_ADDR_ID_LOW: begin
        read_byte[CWF_LOW_HI:CWF_LOW_LO] = s.cfg.ident[4:0];
        read_byte[CWF_RTR_POS]           = s.cfg.rtr;
        read_byte[CWF_IDE_POS]           = s.cfg.ide;
      end
      CWF_ADDR_MASK_TOP: begin
        read_byte = s.cfg.mask[28:21];
      end
      CWF_ADDR_MASK_UMID: begin
        read_byte = s.cfg.mask[20:13];
      end
      CWF_ADDR_MASK_LMID: begin
        read_byte = s.cfg.mask[12:5];
      end
      CWF_ADDR_MASK_LOW: begin
        read_byte[CWF_LOW_HI:CWF_LOW_LO] = s.cfg.mask[4:0];
      end
      CWF_ADDR_DLC: begin
        read_byte[CWF_DLC_W-1:0] = s.cfg.dlc;
      end
      default: begin
        read_byte = CWF_ZERO_BYTE;
      end
    endcase
  endfunction

  always_comb begin
    armed     = (r.st == CWF_ST_ARMED);
    cfg_write = reg_req.wr && (reg_req.addr >= CWF_ADDR_ID_TOP)
                && (reg_req.addr <= CWF_ADDR_DLC);
    valid_set = reg_req.wr && (reg_req.addr == CWF_ADDR_CTRL)
                && reg_req.wdata[CWF_VALID_POS];
    valid_clr = reg_req.wr && (reg_req.addr == CWF_ADDR_CTRL)
                && !reg_req.wdata[CWF_VALID_POS];
    hit_now   = frame_valid && armed && cmp_match;
  end

  always_comb begin
    n     = r;
    n.hit = hit_now;

    if (reg_req.wr) begin
      case (reg_req.addr)
        CWF_ADDR_ID_TOP: begin
          n.cfg.ident[28:21] = reg_req.wdata;
        end
        CWF_ADDR_ID_UMID: begin
          n.cfg.ident[20:13] = reg_req.wdata;
        end
        CWF_ADDR_ID_LMID: begin
          n.cfg.ident[12:5] = reg_req.wdata;
        end
        CWF_ADDR_ID_LOW: begin
          n.cfg.ident[4:0] = reg_req.wdata[CWF_LOW_HI:CWF_LOW_LO];
          n.cfg.rtr        = reg_req.wdata[CWF_RTR_POS];
          n.cfg.ide        = reg_req.wdata[CWF_IDE_POS];
        end
        CWF_ADDR_MASK_TOP: begin
          n.cfg.mask[28:21] = reg_req.wdata;
        end
        CWF_ADDR_MASK_UMID: begin
          n.cfg.mask[20:13] = reg_req.wdata;
        end
        CWF_ADDR_MASK_LMID: begin
          n.cfg.mask[12:5] = reg_req.wdata;
        end
        CWF_ADDR_MASK_LOW: begin
          n.cfg.mask[4:0] = reg_req.wdata[CWF_LOW_HI:CWF_LOW_LO];
        end
        CWF_ADDR_DLC: begin
          n.cfg.dlc = reg_req.wdata[CWF_DLC_W-1:0];
        end
        default: begin
          n.cfg = r.cfg;
        end
      endcase
    end

    if (reg_req.rd) begin
      n.rdata = read_byte(reg_req.addr, r);
    end

    case (r.st)
      CWF_ST_UNCONF: begin
        if (valid_set) begin
          n.st = CWF_ST_ARMED;
        end
      end
      CWF_ST_ARMED: begin
        // a set arriving with a wake keeps the flag
        if (valid_set) begin
          n.st = CWF_ST_ARMED;
        end else if (hit_now || ext_wake || cfg_write || valid_clr) begin
          n.st = CWF_ST_UNCONF;
        end
      end
      default: begin
        n.st = CWF_ST_UNCONF;
      end
    endcase

    if (restart) begin
      // contents kept, reserved bits are never stored
      n.st  = CWF_ST_UNCONF;
      n.hit = 1'b0;
    end
    if (soft_reset) begin
      n = CWF_REGS_RESET;
    end
    n.bytes = dlc_bytes(n.cfg.dlc);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r <= CWF_REGS_RESET;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata             = r.rdata;
  assign selective_wake_enable = (r.st == CWF_ST_ARMED);
  assign wake_up_frame_hit     = r.hit;
  assign wake_frame_bytes      = r.bytes;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_plain_rd(logic [6:0] a);
    reg_req.rd && !reg_req.wr && !soft_reset && reg_req.addr == a;
  endsequence

  sequence s_write_then_read(logic [6:0] a);
    (reg_req.wr && !reg_req.rd && !soft_reset && reg_req.addr == a)
      ##1 (reg_req.rd && !reg_req.wr && !soft_reset && reg_req.addr == a);
  endsequence

  AST_ID_TOP_ROUNDTRIP: assert property (
    s_write_then_read(CWF_ADDR_ID_TOP) |=> reg_rdata == $past(reg_req.wdata, 2))
    else $error("top identifier byte not read back");

  AST_ID_LOW_FIELDS: assert property (
    (reg_req.wr && !soft_reset && reg_req.addr == CWF_ADDR_ID_LOW) |=>
      r.cfg.ident[4:0] == $past(reg_req.wdata[CWF_LOW_HI:CWF_LOW_LO])
      && r.cfg.rtr == $past(reg_req.wdata[CWF_RTR_POS])
      && r.cfg.ide == $past(reg_req.wdata[CWF_IDE_POS]))
    else $error("low identifier fields misplaced");

  AST_ID_LOW_RSV: assert property (
    s_plain_rd(CWF_ADDR_ID_LOW) |=> (reg_rdata & CWF_ID_LOW_RSV) == CWF_ZERO_BYTE)
    else $error("identifier reserved bit read as one");

  AST_MASK_LOW_RSV: assert property (
    s_plain_rd(CWF_ADDR_MASK_LOW) |=> (reg_rdata & CWF_MASK_LOW_RSV) == CWF_ZERO_BYTE)
    else $error("mask reserved bits read as one");

  AST_DLC_RSV: assert property (
    s_plain_rd(CWF_ADDR_DLC) |=> (reg_rdata & CWF_DLC_RSV) == CWF_ZERO_BYTE
      && reg_rdata[CWF_DLC_W-1:0] == $past(r.cfg.dlc))
    else $error("length register read wrong");

  AST_DLC_BYTES: assert property (
    wake_frame_bytes == ((r.cfg.dlc > CWF_DLC_MAX_BYTES) ? CWF_DLC_MAX_BYTES : r.cfg.dlc))
    else $error("byte count does not follow length code");

  AST_SOFT_CLEAR: assert property (
    soft_reset |=> r.cfg == '0 && !selective_wake_enable && reg_rdata == CWF_ZERO_BYTE)
    else $error("soft reset left state behind");

  AST_RESTART_KEEP: assert property (
    (restart && !soft_reset && !cfg_write) |=> r.cfg == $past(r.cfg) && !selective_wake_enable)
    else $error("restart changed configuration");

  AST_HIT_NEEDS_VALID: assert property (
    wake_up_frame_hit |-> $past(selective_wake_enable) && $past(frame_valid))
    else $error("wake reported while not enabled");

  AST_HIT_CLEARS_VALID: assert property (
    wake_up_frame_hit |-> !selective_wake_enable || $past(valid_set))
    else $error("valid flag survived a wake");

  AST_CFG_WRITE_CLEARS: assert property (
    (cfg_write && !restart) |=> !selective_wake_enable)
    else $error("valid flag survived a configuration write");

  AST_MATCH_FULL: assert property (
    wake_up_frame_hit |-> $past(frame.dlc) == $past(r.cfg.dlc)
      && $past(frame.ide) == $past(r.cfg.ide)
      && $past(frame.rtr) == $past(r.cfg.rtr))
    else $error("wake accepted on mismatched frame");

endmodule

// file: cwf_wake_filter_tb.sv
module cwf_wake_filter_tb
  import cwf_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [28:0] XID = 29'h0b5a3c96;
  localparam logic [10:0] SID = 11'h5a3;

  logic            ref_clk;
  logic            reset;
  logic            soft_reset;
  logic            restart;
  logic            ext_wake;
  logic            frame_valid;
  logic            selective_wake_enable;
  logic            wake_up_frame_hit;
  logic [3:0]      wake_frame_bytes;
  logic [7:0]      reg_rdata;
  logic [7:0]      rv;
  cwf_reg_req_type reg_req;
  cwf_frame_type   frame;
  int              n_mismatch;
  int              compares;

  cwf_wake_filter DUT (.ref_clk(ref_clk), .reset(reset), .soft_reset(soft_reset),
    .restart(restart), .reg_req(reg_req), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
    .frame(frame), .ext_wake(ext_wake), .selective_wake_enable(selective_wake_enable),
    .wake_up_frame_hit(wake_up_frame_hit), .wake_frame_bytes(wake_frame_bytes));

  cwf_can_node node (.ref_clk(ref_clk), .frame_valid(frame_valid), .frame(frame));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #2;
    reg_req = '0;
  endtask

  task automatic rd(input logic [6:0] a);
    @(posedge ref_clk);
    #2;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #2;
    reg_req = '0;
    rv = reg_rdata;
  endtask

  // write and read of one location on consecutive edges
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #2;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #2;
    reg_req = '0;
    rv = reg_rdata;
  endtask

  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #2;
    s = 1'b1;
    @(posedge ref_clk);
    #2;
    s = 1'b0;
  endtask

  // value read back after every location 0x22..0x2c was written with ff (fd at 0x26)
  function automatic logic [7:0] expv(input logic [6:0] a);
    case (a)
      CWF_ADDR_ID_LOW:   return 8'h7d;
      CWF_ADDR_MASK_LOW: return 8'h7c;
      CWF_ADDR_DLC:      return 8'h0f;
      7'h22, 7'h2c:      return 8'h00;
      default:           return 8'hff;
    endcase
  endfunction

  task automatic readall(input logic zero);
    for (int a = 34; a <= 44; a++) begin
      rd(7'(a));
      chk8(rv, zero ? 8'h00 : expv(7'(a)), "register read");
    end
  endtask

  task automatic cfg(input logic [28:0] id, input logic [28:0] m, input logic ide,
                     input logic [3:0] dlc);
    wr(CWF_ADDR_ID_TOP, id[28:21]);
    wr(CWF_ADDR_ID_UMID, id[20:13]);
    wr(CWF_ADDR_ID_LMID, id[12:5]);
    wr(CWF_ADDR_ID_LOW, {1'b0, id[4:0], 1'b0, ide});
    wr(CWF_ADDR_MASK_TOP, m[28:21]);
    wr(CWF_ADDR_MASK_UMID, m[20:13]);
    wr(CWF_ADDR_MASK_LMID, m[12:5]);
    wr(CWF_ADDR_MASK_LOW, {1'b0, m[4:0], 2'b00});
    wr(CWF_ADDR_DLC, {4'h0, dlc});
    wr(CWF_ADDR_CTRL, 8'h01);
  endtask

  task automatic try(input logic ide, input logic rtr, input logic [28:0] id,
                     input logic [3:0] dlc, input logic exp);
    node.send('{ide: ide, rtr: rtr, ident: id, dlc: dlc});
    chk1(wake_up_frame_hit, exp, "wake hit");
    if (exp) begin
      chk1(selective_wake_enable, 1'b0, "enable after wake");
      wr(CWF_ADDR_CTRL, 8'h01);
    end
  endtask

  initial begin
    #(25ns * 20000);
    n_mismatch++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    soft_reset = 1'b0;
    restart = 1'b0;
    ext_wake = 1'b0;
    reg_req = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    readall(1'b1);
    for (int a = 34; a <= 44; a++) begin
      wr(7'(a), (a == 38) ? 8'hfd : 8'hff);
    end
    readall(1'b0);
    $display("test register_map done");
    wr(CWF_ADDR_CTRL, 8'h01);
    chk1(selective_wake_enable, 1'b1, "enable armed");
    pulse(restart);
    chk1(selective_wake_enable, 1'b0, "enable after restart");
    readall(1'b0);
    wr_rd(CWF_ADDR_ID_TOP, 8'ha5);
    chk8(rv, 8'ha5, "write then read");
    pulse(soft_reset);
    readall(1'b1);
    $display("test restart_soft_reset done");
    for (int c = 0; c < 16; c++) begin
      wr(CWF_ADDR_DLC, 8'(c));
      @(posedge ref_clk);
      #2;
      chk8({4'h0, wake_frame_bytes}, c < 8 ? 8'(c) : 8'h08, "byte count");
    end
    $display("test length_code done");
    cfg(XID, 29'h1fffffff, 1'b1, 4'h5);
    try(1'b1, 1'b0, XID ^ 29'h1, 4'h5, 1'b0);
    try(1'b0, 1'b0, XID, 4'h5, 1'b0);
    try(1'b1, 1'b1, XID, 4'h5, 1'b0);
    try(1'b1, 1'b0, XID, 4'h5, 1'b1);
    cfg(XID, 29'h1ffffffe, 1'b1, 4'h8);
    try(1'b1, 1'b0, XID ^ 29'h1, 4'h9, 1'b0);
    try(1'b1, 1'b0, XID ^ 29'h1, 4'h8, 1'b1);
    cfg({SID, 18'h0}, {11'h7ff, 18'h0}, 1'b0, 4'h2);
    try(1'b0, 1'b0, {18'h0, SID ^ 11'h400}, 4'h2, 1'b0);
    try(1'b0, 1'b0, {18'h0, SID}, 4'h2, 1'b1);
    cfg(XID, 29'h0, 1'b1, 4'h3);
    try(1'b1, 1'b0, ~XID, 4'h3, 1'b1);
    $display("test frame_match done");
    wr(CWF_ADDR_MASK_TOP, 8'hff);
    chk1(selective_wake_enable, 1'b0, "enable after config write");
    try(1'b0, 1'b0, {18'h0, SID}, 4'h2, 1'b0);
    wr(CWF_ADDR_CTRL, 8'h01);
    pulse(ext_wake);
    chk1(selective_wake_enable, 1'b0, "enable after other wake");
    $display("test valid_flag done");
    report_and_stop();
  end
endmodule
